/* hdl/line_sampler.sv */
// Two-wire line synchroniser, START/STOP detector and quarter-bit tick
`timescale 1ns/1ns
`default_nettype none
module line_sampler
   import twm_pkg::*;
#(
   parameter int RATE_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire line_t             line_in,
   input  wire logic [RATE_W-1:0] rate,
   output var  line_t             line_q,
   output var  line_ev_t          ev
);

   typedef struct packed {
      line_t             s1;
      line_t             s2;
      line_t             prev;
      logic [RATE_W-1:0] cnt;
      line_ev_t          ev;
   } smp_t;

   smp_t smp_r;
   smp_t smp_nxt;

   always_comb begin
      smp_nxt      = smp_r;
      smp_nxt.s1   = line_in;
      smp_nxt.s2   = smp_r.s1;
      smp_nxt.prev = smp_r.s2;
      // Conditions are only judged on the second stage and later
      smp_nxt.ev.start_det = smp_r.prev.scl & smp_r.s2.scl & smp_r.prev.sda & ~smp_r.s2.sda;
      smp_nxt.ev.stop_det  = smp_r.prev.scl & smp_r.s2.scl & ~smp_r.prev.sda & smp_r.s2.sda;
      if (smp_r.cnt == '0) begin
         smp_nxt.cnt     = rate;
         smp_nxt.ev.tick = 1'b1;
      end else begin
         smp_nxt.cnt     = smp_r.cnt - 1'b1;
         smp_nxt.ev.tick = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         smp_r <= '0;
      end else begin
         smp_r <= smp_nxt;
      end
   end

   assign line_q = smp_r.s2;
   assign ev     = smp_r.ev;

endmodule
`default_nettype wire

/* hdl/twm_pkg.sv */
// Constants, types and register map of the two-wire master controller
package twm_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_STATUS  = 8'h04;
   localparam logic [7:0] A_DATA    = 8'h08;
   localparam logic [7:0] A_BITRATE = 8'h0C;
   localparam logic [7:0] A_INT_ST  = 8'h10;
   localparam logic [7:0] A_INT_MSK = 8'h14;

   // ----------------------------------------------------------------
   // Control register bit positions
   // ----------------------------------------------------------------
   localparam int B_FLAG  = 7;
   localparam int B_ACK   = 6;
   localparam int B_START = 5;
   localparam int B_STOP  = 4;
   localparam int B_EN    = 2;

   // ----------------------------------------------------------------
   // Interrupt status bits
   // ----------------------------------------------------------------
   localparam int EV_W     = 3;
   localparam int EV_FLAG  = 0;
   localparam int EV_ARB   = 1;
   localparam int EV_ERROR = 2;

   // ----------------------------------------------------------------
   // Status codes
   // ----------------------------------------------------------------
   localparam logic [7:0] code_bus_error      = 8'h00;
   localparam logic [7:0] code_start          = 8'h08;
   localparam logic [7:0] code_rstart         = 8'h10;
   localparam logic [7:0] tx_addr_acked_code  = 8'h18;
   localparam logic [7:0] code_tx_addr_nack   = 8'h20;
   localparam logic [7:0] tx_byte_acked_code  = 8'h28;
   localparam logic [7:0] code_tx_byte_nack   = 8'h30;
   localparam logic [7:0] code_arb_lost       = 8'h38;
   localparam logic [7:0] code_rx_addr_ack    = 8'h40;
   localparam logic [7:0] code_rx_addr_nack   = 8'h48;
   localparam logic [7:0] code_rx_byte_ack    = 8'h50;
   localparam logic [7:0] code_rx_byte_nack   = 8'h58;
   localparam logic [7:0] code_idle           = 8'hF8;

   // ----------------------------------------------------------------
   // Bit sequencing
   // ----------------------------------------------------------------
   localparam logic [1:0] PH_LOW    = 2'h0;
   localparam logic [1:0] PH_RISE   = 2'h1;
   localparam logic [1:0] PH_SAMPLE = 2'h2;
   localparam logic [1:0] PH_FALL   = 2'h3;
   localparam logic [3:0] ACK_SLOT  = 4'h8;

   typedef enum logic [2:0] {ENG_IDLE, ENG_WAIT_FREE, ENG_START, ENG_BIT, ENG_STOP, ENG_HOLD} engine_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_t;

   typedef struct packed {
      logic start_det;
      logic stop_det;
      logic tick;
   } line_ev_t;

endpackage

/* hdl/two_wire_master_receiver.sv */
// Two-wire bus master controller with APB register access
`timescale 1ns/1ns
`default_nettype none
module two_wire_master_receiver
   import twm_pkg::*;
#(
   parameter int RATE_W = 8
) (
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        SCL_IN,
   output var  logic        SCL_OUT,
   output var  logic        SCL_OE,
   input  wire logic        SDA_IN,
   output var  logic        SDA_OUT,
   output var  logic        SDA_OE,
   output var  logic        IRQ
);

   typedef struct packed {
      engine_t           state;
      logic [1:0]        phase;
      logic [3:0]        cnt;
      logic [7:0]        data;
      logic [7:0]        status;
      logic [RATE_W-1:0] bitrate;
      logic              flag;
      logic              ack_enable;
      logic              start_request;
      logic              stop_request;
      logic              iface_enable;
      logic              owner;
      logic              busy;
      logic              rx_mode;
      logic              addr_phase;
      logic              pend_start;
      logic              ack;
      logic [EV_W-1:0]   int_stat;
      logic [EV_W-1:0]   int_mask;
      logic              scl_oe;
      logic              sda_oe;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      logic              irq;
   } ctl_t;

   ctl_t     s_r;
   ctl_t     s_nxt;
   line_t    line_q;
   line_ev_t ev;

   line_sampler #(.RATE_W(RATE_W)) u_sampler (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .line_in ('{scl: SCL_IN, sda: SDA_IN}),
      .rate    (s_r.bitrate),
      .line_q  (line_q),
      .ev      (ev)
   );

   // ----------------------------------------------------------------
   // Combinational helpers
   // ----------------------------------------------------------------
   logic              setup;
   logic              wr;
   logic              adv;
   logic              rx_data;
   logic              bit_val;
   logic              checked;
   logic              hit;
   logic [31:0]       rd;
   logic [7:0]        ctrl_rd;
   logic              set_flag;
   logic [7:0]        set_code;
   logic [EV_W-1:0]   ev_set;
   logic              clr;

   assign setup   = PSEL & ~PENABLE;
   assign wr      = PSEL & PENABLE & s_r.pready & PWRITE;
   // Phase after SCL release waits for the line to go high: slaves may stretch
   assign adv     = ev.tick & ~(s_r.phase == PH_SAMPLE & ~line_q.scl);
   assign rx_data = s_r.rx_mode & ~s_r.addr_phase;
   assign bit_val = rx_data ? ((s_r.cnt == ACK_SLOT) ? ~s_r.ack_enable : 1'b1)
                            : ((s_r.cnt == ACK_SLOT) ? 1'b1 : s_r.data[7]);
   // Bits whose released level another master may override
   assign checked = bit_val & (rx_data ? (s_r.cnt == ACK_SLOT) : (s_r.cnt != ACK_SLOT));
   assign ctrl_rd = {s_r.flag, s_r.ack_enable, s_r.start_request, s_r.stop_request,
                     1'b0, s_r.iface_enable, 2'b00};
   assign clr     = PWDATA[B_FLAG] & PWDATA[B_EN];

   always_comb begin
      hit = 1'b1;
      rd  = '0;
      case (PADDR)
         A_CTRL:    rd[7:0] = ctrl_rd;
         A_STATUS:  rd[7:0] = s_r.flag ? s_r.status : code_idle;
         A_DATA:    rd[7:0] = s_r.data;
         A_BITRATE: rd[RATE_W-1:0] = s_r.bitrate;
         A_INT_ST:  rd[EV_W-1:0] = s_r.int_stat;
         A_INT_MSK: rd[EV_W-1:0] = s_r.int_mask;
         default:   hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt    = s_r;
      set_flag = 1'b0;
      set_code = s_r.status;
      ev_set   = '0;

      s_nxt.pready  = setup;
      s_nxt.pslverr = setup & ~hit;
      if (setup & ~PWRITE) begin
         s_nxt.prdata = rd;
      end
      if (ev.start_det) begin
         s_nxt.busy = 1'b1;
      end else if (ev.stop_det) begin
         s_nxt.busy = 1'b0;
      end

      case (s_r.state)
         ENG_IDLE: begin
            s_nxt.scl_oe = 1'b0;
            s_nxt.sda_oe = 1'b0;
         end
         ENG_WAIT_FREE: begin
            if (!s_r.busy) begin
               s_nxt.state = ENG_START;
               s_nxt.phase = PH_LOW;
            end
         end
         ENG_START: begin
            if (adv) begin
               s_nxt.phase = s_r.phase + 1'b1;
               case (s_r.phase)
                  PH_LOW:    s_nxt.sda_oe = 1'b0;
                  PH_RISE:   s_nxt.scl_oe = 1'b0;
                  PH_SAMPLE: s_nxt.sda_oe = 1'b1;
                  default: begin
                     s_nxt.scl_oe = 1'b1;
                     s_nxt.owner  = 1'b1;
                     s_nxt.state  = ENG_HOLD;
                     set_flag     = 1'b1;
                     set_code     = s_r.owner ? code_rstart : code_start;
                  end
               endcase
            end
         end
         ENG_BIT: begin
            if (ev.start_det | ev.stop_det) begin
               // Misplaced condition: give up the bus without a STOP
               s_nxt.state  = ENG_HOLD;
               s_nxt.owner  = 1'b0;
               s_nxt.scl_oe = 1'b0;
               s_nxt.sda_oe = 1'b0;
               set_flag     = 1'b1;
               set_code     = code_bus_error;
               ev_set[EV_ERROR] = 1'b1;
            end else if (adv) begin
               s_nxt.phase = s_r.phase + 1'b1;
               case (s_r.phase)
                  PH_LOW: begin
                     s_nxt.scl_oe = 1'b1;
                     s_nxt.sda_oe = ~bit_val;
                  end
                  PH_RISE: s_nxt.scl_oe = 1'b0;
                  PH_SAMPLE: begin
                     s_nxt.ack = line_q.sda;
                     if (s_r.cnt != ACK_SLOT) begin
                        s_nxt.data = {s_r.data[6:0], rx_data ? line_q.sda : s_r.data[7]};
                     end
                     if (checked & ~line_q.sda) begin
                        s_nxt.state  = ENG_HOLD;
                        s_nxt.owner  = 1'b0;
                        s_nxt.scl_oe = 1'b0;
                        s_nxt.sda_oe = 1'b0;
                        set_flag     = 1'b1;
                        set_code     = code_arb_lost;
                        ev_set[EV_ARB] = 1'b1;
                     end
                  end
                  default: begin
                     s_nxt.scl_oe = 1'b1;
                     if (s_r.cnt == ACK_SLOT) begin
                        s_nxt.state = ENG_HOLD;
                        set_flag    = 1'b1;
                        if (s_r.addr_phase) begin
                           s_nxt.sda_oe = 1'b0;
                           if (s_r.rx_mode) begin
                              set_code = s_r.ack ? code_rx_addr_nack : code_rx_addr_ack;
                           end else begin
                              set_code = s_r.ack ? code_tx_addr_nack : tx_addr_acked_code;
                           end
                        end else if (rx_data) begin
                           set_code = s_r.ack_enable ? code_rx_byte_ack : code_rx_byte_nack;
                        end else begin
                           s_nxt.sda_oe = 1'b0;
                           set_code = s_r.ack ? code_tx_byte_nack : tx_byte_acked_code;
                        end
                     end else begin
                        s_nxt.cnt = s_r.cnt + 1'b1;
                     end
                  end
               endcase
            end
         end
         ENG_STOP: begin
            if (adv) begin
               s_nxt.phase = s_r.phase + 1'b1;
               case (s_r.phase)
                  PH_LOW: begin
                     s_nxt.scl_oe = 1'b1;
                     s_nxt.sda_oe = 1'b1;
                  end
                  PH_RISE:   s_nxt.scl_oe = 1'b0;
                  PH_SAMPLE: s_nxt.sda_oe = 1'b0;
                  default: begin
                     s_nxt.owner        = 1'b0;
                     s_nxt.stop_request = 1'b0;
                     s_nxt.state        = s_r.pend_start ? ENG_START : ENG_IDLE;
                  end
               endcase
            end
         end
         ENG_HOLD: s_nxt.scl_oe = s_r.owner;
         default:  s_nxt.state = ENG_IDLE;
      endcase

      if (set_flag) begin
         s_nxt.flag     = 1'b1;
         s_nxt.status   = set_code;
         ev_set[EV_FLAG] = 1'b1;
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (wr & (PADDR == A_CTRL)) begin
         s_nxt.ack_enable    = PWDATA[B_ACK];
         s_nxt.start_request = PWDATA[B_START];
         s_nxt.stop_request  = PWDATA[B_STOP];
         s_nxt.iface_enable  = PWDATA[B_EN];
         if (!PWDATA[B_EN]) begin
            s_nxt.state  = ENG_IDLE;
            s_nxt.flag   = 1'b0;
            s_nxt.owner  = 1'b0;
            s_nxt.scl_oe = 1'b0;
            s_nxt.sda_oe = 1'b0;
         end else if (s_r.flag & clr) begin
            s_nxt.flag  = 1'b0;
            // Bit count restarts only here, phase here and on leaving the free-bus wait, so a control write mid-byte that keeps the enable bit set leaves the frame intact
            s_nxt.phase = PH_LOW;
            s_nxt.cnt   = '0;
            if (s_r.status == code_bus_error) begin
               s_nxt.state        = ENG_IDLE;
               s_nxt.stop_request = 1'b0;
            end else if (s_r.status == code_arb_lost) begin
               s_nxt.state = PWDATA[B_START] ? ENG_WAIT_FREE : ENG_IDLE;
            end else if (PWDATA[B_STOP]) begin
               s_nxt.state      = ENG_STOP;
               s_nxt.pend_start = PWDATA[B_START];
            end else if (PWDATA[B_START] & (s_r.status != code_start) & (s_r.status != code_rstart)) begin
               s_nxt.state = ENG_START;
            end else begin
               s_nxt.state      = ENG_BIT;
               s_nxt.addr_phase = (s_r.status == code_start) | (s_r.status == code_rstart);
               if ((s_r.status == code_start) | (s_r.status == code_rstart)) begin
                  s_nxt.rx_mode = s_r.data[0];
               end
            end
         end else if (~s_r.flag & PWDATA[B_START] & (s_r.state == ENG_IDLE)) begin
            s_nxt.state = ENG_WAIT_FREE;
         end
      end
      // Data only changes while nothing is shifting
      if (wr & (PADDR == A_DATA) & (s_r.flag | (s_r.state == ENG_IDLE))) begin
         s_nxt.data = PWDATA[7:0];
      end
      if (wr & (PADDR == A_BITRATE)) begin
         s_nxt.bitrate = PWDATA[RATE_W-1:0];
      end
      if (wr & (PADDR == A_INT_MSK)) begin
         s_nxt.int_mask = PWDATA[EV_W-1:0];
      end
      // An event in the clearing cycle survives the clear
      s_nxt.int_stat = ((wr & (PADDR == A_INT_ST)) ? (s_r.int_stat & ~PWDATA[EV_W-1:0]) : s_r.int_stat)
                       | ev_set;
      s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign PRDATA  = s_r.prdata;
   assign PREADY  = s_r.pready;
   assign PSLVERR = s_r.pslverr;
   assign SCL_OE  = s_r.scl_oe;
   assign SDA_OE  = s_r.sda_oe;
   assign IRQ     = s_r.irq;
   // Open-drain pins only ever pull low
   assign SCL_OUT = 1'b0;
   assign SDA_OUT = 1'b0;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_status_idle_code: assert property (@(posedge MCLK) disable iff (!RST_N)
      (setup & ~PWRITE & (PADDR == A_STATUS) & ~s_r.flag) |=> (PRDATA[7:0] == code_idle))
      else $error("status not F8 while flag clear");
   a_hold_scl_low: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_r.state == ENG_HOLD & s_r.flag & s_r.owner) |-> SCL_OE)
      else $error("clock not held low during hold");
   a_flag_clear_write: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr & (PADDR == A_CTRL) & clr & s_r.flag) |=> (!s_r.flag && s_r.state != ENG_HOLD))
      else $error("flag clear did not resume");
   a_start_sets_flag: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_r.state == ENG_START & s_r.phase == PH_FALL & adv)
      |=> (s_r.flag && (s_r.status == code_start || s_r.status == code_rstart)))
      else $error("START did not raise the flag");
   a_rx_ack_level: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_r.state == ENG_BIT & rx_data & s_r.cnt == ACK_SLOT & s_r.phase == PH_SAMPLE)
      |-> (SDA_OE == s_r.ack_enable))
      else $error("wrong acknowledge level");
   a_stop_clears_bit: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_r.state == ENG_STOP & s_r.phase == PH_FALL & adv & ~(wr & (PADDR == A_CTRL)))
      |=> !s_r.stop_request)
      else $error("stop request not cleared");
   a_arb_release: assert property (@(posedge MCLK) disable iff (!RST_N)
      ($rose(s_r.flag) && s_r.status == code_arb_lost) |-> (!SCL_OE && !SDA_OE && !s_r.owner))
      else $error("bus not released after arbitration loss");
   a_bus_error_code: assert property (@(posedge MCLK) disable iff (!RST_N)
      (s_r.state == ENG_BIT & (ev.start_det | ev.stop_det) & ~(wr & (PADDR == A_CTRL)))
      |=> (s_r.flag && s_r.status == code_bus_error && !SDA_OE))
      else $error("bus error not reported");
   a_write_addr_mode: assert property (@(posedge MCLK) disable iff (!RST_N)
      (wr & (PADDR == A_CTRL) & clr & s_r.flag & ~PWDATA[B_STOP] & (s_r.status == code_rstart) & ~s_r.data[0])
      |=> (s_r.state == ENG_BIT && s_r.addr_phase && !s_r.rx_mode))
      else $error("write address did not select transmitter");
   a_flag_after_byte: assert property (@(posedge MCLK) disable iff (!RST_N)
      ($rose(s_r.flag) && (s_r.status == code_rx_byte_ack || s_r.status == code_rx_addr_ack))
      |-> ($past(s_r.state) == ENG_BIT && $past(s_r.cnt) == ACK_SLOT))
      else $error("flag set before acknowledge bit");

endmodule
`default_nettype wire

/* verification/slave_model.sv */
// Behavioural bus slave that answers reads with a counting byte pattern
`timescale 1ns/1ns
`default_nettype none
module slave_model #(
   parameter logic [6:0] ADDR = 7'h32
) (
   input  wire logic scl,
   input  wire logic sda,
   output var  logic sda_oe
);
   logic [3:0] n = 4'h0;
   logic [7:0] sh = 8'h00;
   logic [7:0] tx = 8'hA5;
   logic       adr = 1'b0;
   logic       rd = 1'b0;
   initial sda_oe = 1'b0;
   // A START, repeated or not, restarts the frame
   always @(negedge sda) begin
      if (scl) begin
         n = 4'h0;
         adr = 1'b1;
         rd = 1'b0;
         tx = 8'hA5;
      end
   end
   always @(posedge scl) begin
      if (n < 4'h8)
         sh = {sh[6:0], sda};
      else if (rd && !sda_oe && sda)
         rd = 1'b0;
      else if (rd && !sda_oe)
         tx = tx + 8'h11;
      n = (n == 4'h8) ? 4'h0 : n + 4'h1;
   end
   // Data only moves while the clock is low, so no false START or STOP
   always @(negedge scl) begin
      if (n == 4'h8 && adr) begin
         adr = 1'b0;
         rd = (sh[7:1] == ADDR) && sh[0];
         sda_oe = (sh[7:1] == ADDR);
      end else if (rd && n < 4'h8)
         sda_oe = ~tx[3'h7 - n[2:0]];
      else
         sda_oe = 1'b0;
   end
endmodule
`default_nettype wire

/* verification/two_wire_master_receiver_bench.sv */
// Self-checking bench: registers, read transfers, refused address, restarts
`timescale 1ns/1ns
`default_nettype none
module two_wire_master_receiver_bench
   import twm_pkg::*;
;
   localparam logic [6:0] ADDR = 7'h32;
   logic        MCLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic        PREADY, PSLVERR, SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, IRQ, s_oe, err;
   logic [31:0] d;
   logic        rival = 1'b0;
   wire logic   scl = ~SCL_OE;
   wire logic   sda = ~(SDA_OE | s_oe | rival);
   int          mismatches = 0;
   int          total_checks = 0;
   always #4 MCLK = ~MCLK;
   two_wire_master_receiver u_dut (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda),
      .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));
   slave_model #(.ADDR(ADDR)) u_slave (.scl(scl), .sda(sda), .sda_oe(s_oe));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int i;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= wd;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      // Ready, read data and error are all taken at the edge that completes the access
      for (i = 0; i < 20; i++) begin
         @(posedge MCLK);
         if (PREADY === 1'b1) break;
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (i == 20) begin
         mismatches++;
         final_report();
      end
   endtask
   // Waits for the flag; the clock stays held low unless the bus was given up
   task automatic wait_flag(input logic [7:0] exp);
      int i;
      for (i = 0; i < 4000 && IRQ !== 1'b1; i++) @(negedge MCLK);
      if (i == 4000) begin
         mismatches++;
         final_report();
      end
      chk(32'(scl), 32'(exp == code_arb_lost || exp == code_bus_error));
      apb(1'b0, A_STATUS, 32'h0, d);
      chk(d, {24'h0, exp});
   endtask
   // Clears the pending event, hands the control word over and waits for the flag
   task automatic step(input logic [7:0] c, input logic [7:0] exp);
      apb(1'b1, A_INT_ST, 32'h1, d);
      apb(1'b1, A_CTRL, {24'h0, c}, d);
      wait_flag(exp);
   endtask
   task automatic stop_bus();
      int i;
      apb(1'b1, A_INT_ST, 32'h1, d);
      apb(1'b1, A_CTRL, 32'h94, d);
      for (i = 0; i < 100; i++) begin
         apb(1'b0, A_CTRL, 32'h0, d);
         if (d[B_STOP] === 1'b0) break;
      end
      chk(32'(d[B_STOP]), 32'h0);
      repeat (2) @(negedge MCLK);
      chk({29'h0, scl, sda, IRQ}, 32'h6);
   endtask
   task automatic t_regs();
      apb(1'b0, A_STATUS, 32'h0, d);
      chk(d, 32'hF8);
      apb(1'b0, 8'h40, 32'h0, d);
      chk(32'(err), 32'h1);
      apb(1'b1, A_BITRATE, 32'h3, d);
      apb(1'b0, A_BITRATE, 32'h0, d);
      chk(d, 32'h3);
      chk({30'h0, SCL_OUT, SDA_OUT}, 32'h0);
      apb(1'b1, A_INT_MSK, 32'h1, d);
      $display("register test done");
   endtask
   task automatic t_read();
      step(8'h24, code_start);
      apb(1'b1, A_INT_MSK, 32'h0, d);
      repeat (2) @(negedge MCLK);
      chk(32'(IRQ), 32'h0);
      apb(1'b1, A_INT_MSK, 32'h1, d);
      repeat (2) @(negedge MCLK);
      chk(32'(IRQ), 32'h1);
      apb(1'b1, A_DATA, {24'h0, ADDR, 1'b1}, d);
      step(8'h84, code_rx_addr_ack);
      step(8'hC4, code_rx_byte_ack);
      apb(1'b0, A_DATA, 32'h0, d);
      chk(d, 32'hA5);
      step(8'h84, code_rx_byte_nack);
      apb(1'b0, A_DATA, 32'h0, d);
      chk(d, 32'hB6);
      stop_bus();
      $display("read test done");
   endtask
   task automatic t_nack();
      step(8'h24, code_start);
      apb(1'b1, A_DATA, {24'h0, ~ADDR, 1'b1}, d);
      step(8'h84, code_rx_addr_nack);
      step(8'hB4, code_start);
      apb(1'b0, A_CTRL, 32'h0, d);
      chk(32'(d[B_STOP]), 32'h0);
      apb(1'b1, A_DATA, {24'h0, ~ADDR, 1'b1}, d);
      step(8'h84, code_rx_addr_nack);
      step(8'hA4, code_rstart);
      apb(1'b1, A_DATA, {24'h0, ADDR, 1'b0}, d);
      step(8'h84, tx_addr_acked_code);
      stop_bus();
      $display("refusal test done");
   endtask
   // Another master holds SDA low through the address: lose, then restart once the bus is free
   task automatic t_arb();
      step(8'h24, code_start);
      apb(1'b1, A_DATA, {24'h0, ADDR, 1'b1}, d);
      rival <= 1'b1;
      step(8'h84, code_arb_lost);
      apb(1'b0, A_INT_ST, 32'h0, d);
      chk(d, 32'h3);
      apb(1'b1, A_INT_ST, 32'h3, d);
      apb(1'b1, A_CTRL, 32'hA4, d);
      repeat (100) @(posedge MCLK);
      chk({30'h0, IRQ, scl}, 32'h1);
      apb(1'b0, A_STATUS, 32'h0, d);
      chk(d, 32'hF8);
      rival <= 1'b0;
      wait_flag(code_start);
      stop_bus();
      $display("arbitration test done");
   endtask
   initial begin
      repeat (3) @(posedge MCLK);
      RST_N <= 1'b1;
      t_regs();
      t_read();
      t_nack();
      t_arb();
      final_report();
   end
endmodule
`default_nettype wire
